/* File: hw/fsp_host.sv */
// Host sequencer for flash self-programming: Wishbone slave for software, device port master.
// Assumes the device port partner is the flash controller; one clock, synchronous reset.
//
// Summary of operation
// - Keys written in order, nothing between
// - Key is 0x55 then 0xAA
// - Interrupts kept away during key writes
// - Two idle slots after setting start
// - Write all 128 latches before row program
// - Page erase control word is 0x4042
// - Row program control word is 0x4002
// - Word pair control word is 0x4001
// - Config write control word is 0x4000
// - Config write needs internal fast RC clock
// - Clock switch mode must be 00 first
//
// Our own choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "fsp_regs.svh"

module fsp_host
  import fsp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic osc_on_internal_fast_rc_i,
  input wire logic clock_switch_mode_clear_i,
  output logic dev_req_o,
  output logic dev_we_o,
  output logic [1:0] dev_sel_o,
  output logic [23:0] dev_addr_o,
  output logic [15:0] dev_wdata_o,
  input wire logic dev_ack_i,
  input wire logic [15:0] dev_rdata_i
);

  fsp_host_s q, d;

  logic port_go;
  logic port_we;
  fsp_sel_e port_sel;
  logic [23:0] port_addr;
  logic [15:0] port_wdata;
  logic port_ready;
  logic port_done;
  logic [15:0] port_rdata;
  logic bus_req;
  logic go_req;
  logic [23:0] masked_addr;

  function automatic logic [15:0] ctrl_word(input fsp_op_e op);
    case (op)
      OP_ERASE: ctrl_word = `FSP_CW_ERASE;
      OP_ROW: ctrl_word = `FSP_CW_ROW;
      OP_PAIR: ctrl_word = `FSP_CW_PAIR;
      default: ctrl_word = `FSP_CW_CONFIG;
    endcase
  endfunction

  function automatic logic [23:0] target_addr(input fsp_op_e op, input logic [23:0] t);
    case (op)
      OP_ERASE: target_addr = t & `FSP_PAGE_MASK;
      OP_ROW: target_addr = t & `FSP_ROW_MASK;
      default: target_addr = t;
    endcase
  endfunction

  assign bus_req = wb_cyc_i && wb_stb_i && !q.ack;
  assign go_req = bus_req && wb_we_i && wb_sel_i[1] && (wb_adr_i == `FSP_WB_CTRL) && wb_dat_i[`FSP_CTRL_GO_BIT];

  always_comb begin
    d = q;
    d.ack = 1'b0;
    d.osc_m = osc_on_internal_fast_rc_i;
    d.osc_s = q.osc_m;
    d.csm_m = clock_switch_mode_clear_i;
    d.csm_s = q.csm_m;
    port_go = 1'b0;
    port_we = 1'b1;
    port_sel = SEL_REG;
    port_addr = `FSP_DEV_CTRL;
    port_wdata = 16'h0000;
    masked_addr = target_addr(q.op, q.target);

    // Register access; settings are frozen while a sequence runs
    if (bus_req) begin
      d.ack = 1'b1;
      d.rdat = 32'h00000000;
      if (wb_adr_i == `FSP_WB_CTRL) begin
        d.rdat[`FSP_CTRL_OP_LSB +: 2] = q.op;
        if (wb_we_i && wb_sel_i[0] && q.st == S_IDLE) begin
          d.op = fsp_op_e'(wb_dat_i[`FSP_CTRL_OP_LSB +: 2]);
        end
      end else if (wb_adr_i == `FSP_WB_TARGET) begin
        d.rdat[23:0] = q.target;
        if (wb_we_i && q.st == S_IDLE) begin
          if (wb_sel_i[0]) d.target[7:0] = wb_dat_i[7:0];
          if (wb_sel_i[1]) d.target[15:8] = wb_dat_i[15:8];
          if (wb_sel_i[2]) d.target[23:16] = wb_dat_i[23:16];
        end
      end else if (wb_adr_i == `FSP_WB_LIDX) begin
        d.rdat[6:0] = q.lidx;
        if (wb_we_i && wb_sel_i[0] && q.st == S_IDLE) begin
          d.lidx = wb_dat_i[6:0];
        end
      end else if (wb_adr_i == `FSP_WB_LDATA) begin
        d.rdat[23:0] = q.lat[q.lidx];
        if (wb_we_i && wb_sel_i == 4'hF && q.st == S_IDLE) begin
          d.lat[q.lidx] = wb_dat_i[23:0];
          d.lidx = q.lidx + 7'h01;
        end
      end else if (wb_adr_i == `FSP_WB_STATUS) begin
        d.rdat[`FSP_STAT_BUSY_BIT] = (q.st != S_IDLE);
        d.rdat[`FSP_STAT_DONE_BIT] = q.done;
        d.rdat[`FSP_STAT_REFUSED_BIT] = q.refused;
        d.rdat[`FSP_STAT_OSC_BIT] = q.osc_s && q.csm_s;
        if (wb_we_i && wb_sel_i[0]) begin
          if (wb_dat_i[`FSP_STAT_DONE_BIT]) d.done = 1'b0;
          if (wb_dat_i[`FSP_STAT_REFUSED_BIT]) d.refused = 1'b0;
        end
      end
    end

    // Start of a sequence; later assignments let a hardware set beat a clear
    if (go_req) begin
      if (q.st != S_IDLE) begin
        d.refused = 1'b1;
      end else if (wb_dat_i[`FSP_CTRL_OP_LSB +: 2] == OP_CONFIG && !(q.osc_s && q.csm_s)) begin
        // The go write loads the op itself, so the clock check must look at the written op
        d.refused = 1'b1;
      end else begin
        d.op = fsp_op_e'(wb_dat_i[`FSP_CTRL_OP_LSB +: 2]);
        d.st = (wb_dat_i[`FSP_CTRL_OP_LSB +: 2] == OP_ERASE) ? S_ADDR_HI : S_LATCH_LO;
        d.cnt = 7'h00;
        d.waiting = 1'b0;
      end
    end

    // Each transfer state issues a device access; all but S_POLL advance on its completion, S_POLL once the start bit reads clear
    case (q.st)
      S_LATCH_LO: begin
        port_sel = SEL_TBL_LOW;
        port_wdata = q.lat[q.cnt][15:0];
        if (q.op == OP_CONFIG) begin
          port_addr = q.target;
          port_addr[`FSP_CONFIG_SPACE_BIT] = 1'b1;
        end else begin
          port_addr = {`FSP_LATCH_PAGE, 8'h00, q.cnt, 1'b0};
        end
      end
      S_LATCH_HI: begin
        port_sel = SEL_TBL_HIGH;
        port_addr = {`FSP_LATCH_PAGE, 8'h00, q.cnt, 1'b0};
        port_wdata = {8'h00, q.lat[q.cnt][23:16]};
      end
      S_ADDR_HI: begin
        port_addr = `FSP_DEV_ADDR_HIGH;
        port_wdata = {8'h00, masked_addr[23:16]};
      end
      S_ADDR_LO: begin
        port_addr = `FSP_DEV_ADDR_LOW;
        port_wdata = masked_addr[15:0];
      end
      S_CTRL: begin
        port_wdata = ctrl_word(q.op);
      end
      S_KEY1: begin
        port_addr = `FSP_DEV_KEY;
        port_wdata = `FSP_KEY_FIRST;
      end
      S_KEY2: begin
        port_addr = `FSP_DEV_KEY;
        port_wdata = `FSP_KEY_SECOND;
      end
      S_START: begin
        port_wdata = ctrl_word(q.op) | `FSP_CW_START;
      end
      S_POLL: begin
        port_we = 1'b0;
      end
      default: begin
      end
    endcase

    if (q.st != S_IDLE && q.st != S_GAP) begin
      port_go = !q.waiting;
      if (port_go && port_ready) begin
        d.waiting = 1'b1;
      end
    end

    if (port_done) begin
      d.waiting = 1'b0;
      case (q.st)
        S_LATCH_LO: d.st = (q.op == OP_CONFIG) ? S_ADDR_HI : S_LATCH_HI;
        S_LATCH_HI: begin
          // A row always reloads every latch so stale words never reach the array
          if (q.cnt == ((q.op == OP_ROW) ? `FSP_ROW_LAST : `FSP_PAIR_LAST)) begin
            d.st = S_ADDR_HI;
            d.cnt = 7'h00;
          end else begin
            d.cnt = q.cnt + 7'h01;
            d.st = S_LATCH_LO;
          end
        end
        S_ADDR_HI: d.st = S_ADDR_LO;
        S_ADDR_LO: d.st = S_CTRL;
        S_CTRL: d.st = S_KEY1;
        // Key writes go back to back; this block raises nothing that could intervene
        S_KEY1: d.st = S_KEY2;
        S_KEY2: d.st = S_START;
        S_START: begin
          d.st = S_GAP;
          d.gap = 2'd0;
        end
        S_POLL: begin
          // The device clears the start bit itself when its timed cycle ends
          if (!port_rdata[`FSP_DEV_START_BIT]) begin
            d.st = S_IDLE;
            d.done = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    if (q.st == S_GAP) begin
      if (q.gap == `FSP_START_GAP - 2'd1) begin
        d.st = S_POLL;
      end else begin
        d.gap = q.gap + 2'd1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdat;

  fsp_dev_port u_port (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .go_i(port_go),
    .we_i(port_we),
    .sel_i(port_sel),
    .addr_i(port_addr),
    .wdata_i(port_wdata),
    .ready_o(port_ready),
    .done_o(port_done),
    .rdata_o(port_rdata),
    .dev_req_o(dev_req_o),
    .dev_we_o(dev_we_o),
    .dev_sel_o(dev_sel_o),
    .dev_addr_o(dev_addr_o),
    .dev_wdata_o(dev_wdata_o),
    .dev_ack_i(dev_ack_i),
    .dev_rdata_i(dev_rdata_i)
  );

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_key_first;
    (q.st == S_KEY1 && port_go && port_ready) |=> (dev_wdata_o == `FSP_KEY_FIRST && dev_addr_o == `FSP_DEV_KEY);
  endproperty
  a_key_first: assert property (p_key_first) else $error("first key byte wrong");

  property p_key_second;
    (q.st == S_KEY2 && port_go && port_ready) |=> (dev_wdata_o == `FSP_KEY_SECOND && dev_addr_o == `FSP_DEV_KEY);
  endproperty
  a_key_second: assert property (p_key_second) else $error("second key byte wrong");

  property p_row_word;
    (q.st == S_CTRL && q.op == OP_ROW && port_go && port_ready) |=> (dev_wdata_o == `FSP_CW_ROW);
  endproperty
  a_row_word: assert property (p_row_word) else $error("row control word wrong");

  property p_config_word;
    (q.st == S_START && q.op == OP_CONFIG && port_go && port_ready) |=>
      (dev_wdata_o == (`FSP_CW_CONFIG | `FSP_CW_START));
  endproperty
  a_config_word: assert property (p_config_word) else $error("config start word wrong");

  property p_key_follow;
    (q.st == S_KEY1 && port_done) |=> (q.st == S_KEY2);
  endproperty
  a_key_follow: assert property (p_key_follow) else $error("second key does not follow first");

  property p_start_after_key;
    (q.st == S_KEY2 && port_done) |=> (q.st == S_START);
  endproperty
  a_start_after_key: assert property (p_start_after_key) else $error("start not after key");

  property p_start_word;
    (q.st == S_START && port_go && port_ready) |=> (dev_wdata_o[15] && dev_wdata_o[14] && dev_req_o);
  endproperty
  a_start_word: assert property (p_start_word) else $error("start write lacks enable bits");

  property p_gap;
    (q.st == S_START && port_done) |=> (q.st == S_GAP) [*2] ##1 (q.st == S_POLL);
  endproperty
  a_gap: assert property (p_gap) else $error("start gap not two cycles");

  property p_erase_word;
    (q.st == S_CTRL && q.op == OP_ERASE && port_go && port_ready) |=> (dev_wdata_o == `FSP_CW_ERASE);
  endproperty
  a_erase_word: assert property (p_erase_word) else $error("erase control word wrong");

  property p_row_full;
    (q.st == S_LATCH_HI && port_done && q.op == OP_ROW) |=>
      ((q.st == S_ADDR_HI) == ($past(q.cnt) == `FSP_ROW_LAST));
  endproperty
  a_row_full: assert property (p_row_full) else $error("row left before all latches");

  property p_config_refused;
    (go_req && q.st == S_IDLE && !(q.osc_s && q.csm_s) &&
      wb_dat_i[1:0] == OP_CONFIG) |=> (q.st == S_IDLE && q.refused);
  endproperty
  a_config_refused: assert property (p_config_refused) else $error("config write started on wrong clock");

  property p_erase_align;
    (q.st == S_ADDR_LO && q.op == OP_ERASE && port_go && port_ready) |=> (dev_wdata_o[10:0] == 11'h000);
  endproperty
  a_erase_align: assert property (p_erase_align) else $error("erase address not page aligned");

endmodule

`default_nettype wire

/* File: hw/fsp_regs.svh */
// Offsets, field positions, operation codes and counts of the flash sequencer host.
// Included by the design modules, the flash model and the bench; definitions only.
`ifndef FSP_REGS_SVH
`define FSP_REGS_SVH

// Host registers, byte addresses on the Wishbone side
`define FSP_WB_CTRL 8'h00
`define FSP_WB_TARGET 8'h04
`define FSP_WB_LIDX 8'h08
`define FSP_WB_LDATA 8'h0C
`define FSP_WB_STATUS 8'h10

// Host register fields
`define FSP_CTRL_OP_LSB 0
`define FSP_CTRL_GO_BIT 8
`define FSP_STAT_BUSY_BIT 0
`define FSP_STAT_DONE_BIT 1
`define FSP_STAT_REFUSED_BIT 2
`define FSP_STAT_OSC_BIT 3

// Device register indices on the device port
`define FSP_DEV_CTRL 24'h000000
`define FSP_DEV_ADDR_LOW 24'h000001
`define FSP_DEV_ADDR_HIGH 24'h000002
`define FSP_DEV_KEY 24'h000003

// Device control word fields and operation codes
`define FSP_DEV_START_BIT 15
`define FSP_DEV_OP_WRITE_ENABLE_BIT_BIT 14
`define FSP_CW_ERASE 16'h4042
`define FSP_CW_ROW 16'h4002
`define FSP_CW_PAIR 16'h4001
`define FSP_CW_CONFIG 16'h4000
`define FSP_CW_START 16'h8000

// Unlock key bytes, in the order they are written
`define FSP_KEY_FIRST 16'h0055
`define FSP_KEY_SECOND 16'h00AA

// Latch page used for table writes into the write latches
`define FSP_LATCH_PAGE 8'hFA
`define FSP_ROW_LAST 7'h7F
`define FSP_PAIR_LAST 7'h01
`define FSP_CONFIG_SPACE_BIT 23
`define FSP_PAGE_MASK 24'hFFF800
`define FSP_ROW_MASK 24'hFFFF00

// Idle cycles after the start write before polling
`define FSP_START_GAP 2'd2

`endif

/* File: hw/fsp_pkg.sv */
// Types shared by the flash sequencer host and its device port.
// Constants live in fsp_regs.svh.
package fsp_pkg;

  typedef enum logic [1:0] {
    OP_ERASE,
    OP_ROW,
    OP_PAIR,
    OP_CONFIG
  } fsp_op_e;

  typedef enum logic [1:0] {
    SEL_REG,
    SEL_TBL_LOW,
    SEL_TBL_HIGH
  } fsp_sel_e;

  typedef enum logic [3:0] {
    S_IDLE,
    S_LATCH_LO,
    S_LATCH_HI,
    S_ADDR_HI,
    S_ADDR_LO,
    S_CTRL,
    S_KEY1,
    S_KEY2,
    S_START,
    S_GAP,
    S_POLL
  } fsp_state_e;

  typedef enum logic [1:0] {
    P_IDLE,
    P_REQ,
    P_REL
  } fsp_phase_e;

  typedef struct packed {
    fsp_phase_e ph;
    logic req;
    logic we;
    fsp_sel_e sel;
    logic [23:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic done;
    logic ack_m;
    logic ack_s;
    logic [15:0] rd_m;
    logic [15:0] rd_s;
  } fsp_port_s;

  typedef struct packed {
    fsp_state_e st;
    fsp_op_e op;
    logic [23:0] target;
    logic [6:0] lidx;
    logic [127:0][23:0] lat;
    logic [6:0] cnt;
    logic waiting;
    logic [1:0] gap;
    logic done;
    logic refused;
    logic ack;
    logic [31:0] rdat;
    logic osc_m;
    logic osc_s;
    logic csm_m;
    logic csm_s;
  } fsp_host_s;

endpackage

/* File: hw/fsp_dev_port.sv */
// Four-phase request port towards the flash controller's register and table-write interface.
// Assumes the device answers each request with dev_ack_i and holds it until the request drops.
`timescale 1ns/1ps
`default_nettype none
`include "fsp_regs.svh"

module fsp_dev_port
  import fsp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic we_i,
  input wire fsp_sel_e sel_i,
  input wire logic [23:0] addr_i,
  input wire logic [15:0] wdata_i,
  output logic ready_o,
  output logic done_o,
  output logic [15:0] rdata_o,
  output logic dev_req_o,
  output logic dev_we_o,
  output logic [1:0] dev_sel_o,
  output logic [23:0] dev_addr_o,
  output logic [15:0] dev_wdata_o,
  input wire logic dev_ack_i,
  input wire logic [15:0] dev_rdata_i
);

  fsp_port_s q, d;

  always_comb begin
    d = q;
    d.done = 1'b0;
    // Device answers come from outside this clock; only the second stage is read
    d.ack_m = dev_ack_i;
    d.ack_s = q.ack_m;
    d.rd_m = dev_rdata_i;
    d.rd_s = q.rd_m;
    case (q.ph)
      P_IDLE: begin
        if (go_i) begin
          d.req = 1'b1;
          d.we = we_i;
          d.sel = sel_i;
          d.addr = addr_i;
          d.wdata = wdata_i;
          d.ph = P_REQ;
        end
      end
      P_REQ: begin
        if (q.ack_s) begin
          // Read data is stable while ack stands, so its synchronised copy is safe here
          d.rdata = q.rd_s;
          d.req = 1'b0;
          d.done = 1'b1;
          d.ph = P_REL;
        end
      end
      default: begin
        if (!q.ack_s) begin
          d.ph = P_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign ready_o = (q.ph == P_IDLE);
  assign done_o = q.done;
  assign rdata_o = q.rdata;
  assign dev_req_o = q.req;
  assign dev_we_o = q.we;
  assign dev_sel_o = q.sel;
  assign dev_addr_o = q.addr;
  assign dev_wdata_o = q.wdata;

endmodule

`default_nettype wire

/* File: verification/fsp_flash_model.sv */
// Behavioural flash controller behind the host's device port: registers, unlock key, write latches.
// Assumes a four-phase request from the host; the answer delay is set by the bench.
`timescale 1ns/1ps
`default_nettype none
`include "fsp_regs.svh"

module fsp_flash_model #(
  parameter int BUSY_CYC = 24
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [1:0] sel_i,
  input wire logic [23:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [3:0] delay_i,
  output logic ack_o,
  output logic [15:0] rdata_o
);
  logic [15:0] ctrl, alo, rd, cfg_lat;
  logic [7:0] ahi;
  logic [1:0] key;
  logic [15:0] lat_lo [128];
  logic [7:0] lat_hi [128];
  logic [3:0] wait_n;
  logic [14:0] op_word;
  logic [23:0] op_addr, op_d0, op_d1;
  int busy, n_start;

  // A released data line must not look like a held answer
  assign rdata_o = ack_o ? rd : ~rd;

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      ctrl <= 16'h0000;
      key <= 2'd0;
      busy <= 0;
      wait_n <= 4'h0;
      n_start <= 0;
      rd <= 16'h0000;
    end else begin
      if (busy > 0) begin
        busy <= busy - 1;
        if (busy == 1) ctrl[15] <= 1'b0;
      end
      if (!req_i && ack_o) ack_o <= 1'b0;
      else if (req_i && !ack_o && wait_n < delay_i) wait_n <= wait_n + 4'h1;
      else if (req_i && !ack_o) begin
        ack_o <= 1'b1;
        wait_n <= 4'h0;
        if (!we_i) rd <= (addr_i[1:0] == 2'd0) ? ctrl : (addr_i[1:0] == 2'd1) ? alo : {8'h00, ahi};
        // The latch page also has bit 23 set; it must not be taken for configuration space
        else if (sel_i == 2'd1 && addr_i[23] && addr_i[23:16] != `FSP_LATCH_PAGE) cfg_lat <= wdata_i;
        else if (sel_i == 2'd1) lat_lo[addr_i[7:1]] <= wdata_i;
        else if (sel_i == 2'd2) lat_hi[addr_i[7:1]] <= wdata_i[7:0];
        else begin
          key <= 2'd0;
          case (addr_i[1:0])
            2'd1: alo <= wdata_i;
            2'd2: ahi <= wdata_i[7:0];
            2'd3: key <= (wdata_i == 16'h0055) ? 2'd1 : (wdata_i == 16'h00AA && key == 2'd1) ? 2'd2 : 2'd0;
            default: begin
              ctrl[14:0] <= wdata_i[14:0];
              if (wdata_i[15] && key == 2'd2 && (wdata_i[14] || ctrl[14]) && busy == 0) begin
                ctrl[15] <= 1'b1;
                busy <= BUSY_CYC;
                n_start <= n_start + 1;
                op_word <= wdata_i[14:0];
                op_addr <= {ahi, alo} & (wdata_i[6] ? 24'hFFF800 : (wdata_i[1:0] == 2'b10) ? 24'hFFFF00 :
                  24'hFFFFFF);
                op_d0 <= (wdata_i[1:0] == 2'b00) ? {8'h00, cfg_lat} : {lat_hi[0], lat_lo[0]};
                op_d1 <= wdata_i[0] ? {lat_hi[1], lat_lo[1]} : {lat_hi[127], lat_lo[127]};
              end
            end
          endcase
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench for the flash sequencer host against a behavioural flash controller.
// Assumes the host register map of fsp_regs.svh; each Wishbone answer is awaited for up to 50 cycles, a missing one counts as a mismatch.
`timescale 1ns/1ps
`default_nettype none
`include "fsp_regs.svh"

module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, wbwe = 1'b0, osc_ok = 1'b0, csm_ok = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0, delay = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic ack, req, dwe, dack;
  logic [1:0] dsel;
  logic [23:0] daddr;
  logic [15:0] dwd, drd;
  logic [23:0] lat [128];
  int miscompares = 0, n_compared = 0;

  fsp_host i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wbwe), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .osc_on_internal_fast_rc_i(osc_ok),
    .clock_switch_mode_clear_i(csm_ok), .dev_req_o(req), .dev_we_o(dwe), .dev_sel_o(dsel), .dev_addr_o(daddr),
    .dev_wdata_o(dwd), .dev_ack_i(dack), .dev_rdata_i(drd));
  fsp_flash_model i_dev (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .we_i(dwe), .sel_i(dsel), .addr_i(daddr),
    .wdata_i(dwd), .delay_i(delay), .ack_o(dack), .rdata_o(drd));

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    wbwe <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    if (ack !== 1'b1) miscompares++;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  function automatic logic [15:0] exp_cw(input int op);
    case (op)
      0: return 16'h4042;
      1: return 16'h4002;
      2: return 16'h4001;
      default: return 16'h4000;
    endcase
  endfunction

  function automatic logic [23:0] exp_addr(input int op, input logic [23:0] t);
    return (op == 0) ? (t & 24'hFFF800) : (op == 1) ? (t & 24'hFFFF00) : t;
  endfunction

  // Polls status until done; a stuck busy shows up as a timeout in the compare
  task automatic wait_done(output logic [31:0] s);
    int n;
    n = 0;
    do begin
      wb(1'b0, `FSP_WB_STATUS, 32'h0, s);
      n++;
    end while (s[`FSP_STAT_DONE_BIT] !== 1'b1 && n < 2000);
    check(s[1:0], 2'b10);
  endtask

  task automatic run_op(input int op, input logic [23:0] t);
    logic [31:0] q;
    int n0, cnt;
    cnt = (op == 1) ? 128 : (op == 2) ? 2 : (op == 3) ? 1 : 0;
    delay <= 4'($urandom_range(0, 9));
    wb(1'b1, `FSP_WB_LIDX, 32'h0, q);
    for (int i = 0; i < cnt; i++) begin
      lat[i] = 24'($urandom);
      wb(1'b1, `FSP_WB_LDATA, {8'h00, lat[i]}, q);
    end
    wb(1'b1, `FSP_WB_TARGET, {8'h00, t}, q);
    n0 = i_dev.n_start;
    wb(1'b1, `FSP_WB_CTRL, 32'h100 | op, q);
    // A second go lands while the first operation still runs
    if (op == 0) wb(1'b1, `FSP_WB_CTRL, 32'h100, q);
    wait_done(q);
    check(q[2], op == 0);
    check(i_dev.n_start - n0, 1);
    check(i_dev.op_word, exp_cw(op) & 16'h7FFF);
    check(i_dev.op_addr, exp_addr(op, t));
    if (op != 0) check(i_dev.op_d0, (op == 3) ? {8'h00, lat[0][15:0]} : lat[0]);
    if (op == 1 || op == 2) check(i_dev.op_d1, lat[cnt-1]);
    wb(1'b1, `FSP_WB_STATUS, 32'h6, q);
    wb(1'b0, `FSP_WB_STATUS, 32'h0, q);
    check(q[3:0], 4'b1000);
  endtask

  initial begin
    logic [31:0] q;
    int n0;
    void'($urandom(66964));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `FSP_WB_STATUS, 32'h0, q);
    check(q[2:0], 3'b000);
    wb(1'b0, 8'h20, 32'h0, q);
    check(q, 32'h0);
    // Config write must be refused unless both clock conditions hold
    for (int k = 0; k < 2; k++) begin
      osc_ok <= k[0];
      csm_ok <= !k[0];
      repeat (4) @(posedge clk_i);
      n0 = i_dev.n_start;
      wb(1'b1, `FSP_WB_TARGET, 32'h00800010, q);
      wb(1'b1, `FSP_WB_CTRL, 32'h103, q);
      repeat (20) @(posedge clk_i);
      wb(1'b0, `FSP_WB_STATUS, 32'h0, q);
      check(q[3:0], 4'b0100);
      check(i_dev.n_start - n0, 0);
      wb(1'b1, `FSP_WB_STATUS, 32'h6, q);
    end
    osc_ok <= 1'b1;
    csm_ok <= 1'b1;
    repeat (4) @(posedge clk_i);
    for (int r = 0; r < 2; r++) begin
      for (int op = 0; op < 4; op++) begin
        // Config targets keep bit 16 set so they never fall on the latch page
        run_op(op, (r == 0) ? 24'hFFFFFF : (24'($urandom) | ((op == 3) ? 24'h810000 : 24'h0)));
      end
    end
    conclude();
  end

  initial begin
    #(25ns * 60000);
    miscompares++;
    conclude();
  end
endmodule
`default_nettype wire
